/* pcs_pkg.sv */
// constants for the power-condition subcommand handler
//----------------------------------------------------------------
// Summary of operation
// R1 - low nibble zero selects restore settings
// R2 - sector count names the power condition
// R3 - default bit restores factory timer, enable
// R4 - default clear restores saved timer, enable
// R5 - restore with save copies current timer
// R6 - restore aborts on bad condition or feature
// R7 - abort shows abort and error bits only
// R8 - low nibble one selects go-to condition
// R9 - go-to success halts enabled timers
// R10 - enter condition right after completion
// R11 - stay there until next command, reset
// R12 - go-to aborts on FFh, reserved, unsupported
// R13 - code two sets timer; enable bit5 save bit4
// R14 - timer in cylinder regs, units bit scales
// R15 - set-timer writes current timer value
// R16 - enabled only when enable set, nonzero
// R17 - set-timer save copies timer and enable
// R18 - clamp timer between zero and maximum
// R19 - abort leaves all settings untouched
//----------------------------------------------------------------
package pcs_pkg;
    // feature code and subcommand codes
    localparam logic [7:0] FEAT_EPC = 8'h4A;
    localparam logic [3:0] SUB_RESTORE = 4'h0;
    localparam logic [3:0] SUB_GOTO = 4'h1;
    localparam logic [3:0] SUB_SET_TIMER = 4'h2;
    // sector number field positions
    localparam int BIT_UNITS = 7;
    localparam int BIT_DEFAULT = 6;
    localparam int BIT_ENABLE = 5;
    localparam int BIT_SAVE = 4;
    // condition identifier meaning every condition
    localparam logic [7:0] ID_ALL = 8'hFF;
    // timer sizes, in 100 ms units
    localparam int TIMER_W = 22;
    localparam int SCALED_W = 26;
    localparam logic [TIMER_W-1:0] TIMER_MAX = 22'h3B_FFC4;
    localparam logic [TIMER_W-1:0] TIMER_MIN = 22'h00_0000;
    localparam int UNIT_BASE_MS = 100;
    localparam int UNIT_MINUTE_MS = 60000;
    localparam logic [9:0] MINUTE_SCALE = 10'(UNIT_MINUTE_MS / UNIT_BASE_MS);
    // completion flag layout
    localparam int ERR_ABORT_BIT = 2;
    localparam int STAT_READY_BIT = 6;
    localparam int STAT_ERROR_BIT = 0;
    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h40;
    localparam logic [7:0] STAT_ABORT = 8'h41;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    // handler states
    typedef enum logic [0:0] {PCS_IDLE, PCS_ENTER} pcs_state_t;
endpackage : pcs_pkg

/* pcs_handler.sv */
// power-condition subcommand handler with timer field storage
`timescale 1ns/1ps
module pcs_handler #(
    parameter int NUM_COND = 2,
    parameter logic [NUM_COND-1:0] SUPPORTED_MASK = 2'h3,
    parameter logic [NUM_COND-1:0] CHANGEABLE_MASK = 2'h3,
    parameter logic [NUM_COND-1:0] SAVABLE_MASK = 2'h3,
    parameter logic [NUM_COND-1:0] DEFAULT_EN_MASK = 2'h3,
    parameter logic [pcs_pkg::TIMER_W-1:0] DEFAULT_TIMER = 22'h00_0064
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] feature_in,
    input wire logic [7:0] sector_count_in,
    input wire logic [7:0] sector_number_in,
    input wire logic [7:0] cyl_low_in,
    input wire logic [7:0] cyl_high_in,
    input wire logic extended_power_feature_in,
    output logic done_out,
    output logic [7:0] command_error_flags_out,
    output logic [7:0] command_status_flags_out,
    output logic power_cond_active_out,
    output logic [7:0] power_cond_id_out,
    output logic timers_halted_out,
    output logic [NUM_COND-1:0] cur_timer_en_out
);
    import pcs_pkg::*;

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------

    // true when condition idx is picked by the identifier
    function automatic logic picks(input logic [7:0] id, input int idx);
        return (id == ID_ALL) || (id == 8'(idx));
    endfunction : picks

    // scale the host timer to 100 ms units and clamp it
    function automatic logic [TIMER_W-1:0] to_timer(
        input logic [15:0] raw,
        input logic minutes
    );
        logic [SCALED_W-1:0] scaled;
        // widen before the product so a large minute count cannot wrap
        scaled = minutes ? SCALED_W'(raw) * SCALED_W'(MINUTE_SCALE) : SCALED_W'(raw);
        if (scaled > SCALED_W'(TIMER_MAX)) begin
            return TIMER_MAX;
        end else if (scaled < SCALED_W'(TIMER_MIN)) begin
            return TIMER_MIN;
        end
        return scaled[TIMER_W-1:0];
    endfunction : to_timer

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------

    pcs_state_t state;
    pcs_state_t next_state;
    logic [TIMER_W-1:0] cur_timer [NUM_COND];
    logic [TIMER_W-1:0] next_cur_timer [NUM_COND];
    logic [TIMER_W-1:0] saved_timer [NUM_COND];
    logic [TIMER_W-1:0] next_saved_timer [NUM_COND];
    logic [NUM_COND-1:0] saved_en;
    logic [NUM_COND-1:0] next_saved_en;
    logic [NUM_COND-1:0] next_cur_en;
    logic next_done;
    logic [7:0] next_err;
    logic [7:0] next_stat;
    logic next_active;
    logic [7:0] next_id;
    logic next_halted;

    //------------------------------------------------------------
    // decode and next values
    //------------------------------------------------------------

    // field views of the task-file registers
    logic [3:0] sub_code;
    logic [7:0] cond_id;
    logic save_bit;
    logic [TIMER_W-1:0] req_timer;
    logic raw_nonzero;
    logic epc_cmd;
    assign sub_code = sector_number_in[3:0];
    assign cond_id = sector_count_in; // [R2]
    assign save_bit = sector_number_in[BIT_SAVE]; // [R13]
    assign req_timer = to_timer({cyl_high_in, cyl_low_in},
                                sector_number_in[BIT_UNITS]); // [R14] [R18]
    assign raw_nonzero = ({cyl_high_in, cyl_low_in} != 16'h0000);
    assign epc_cmd = cmd_valid_in && (feature_in == FEAT_EPC);

    // condition checks over all picked conditions
    logic sel_any;
    logic bad_sup;
    logic bad_chg;
    logic bad_save;
    logic abort;
    always_comb begin
        sel_any = 1'b0;
        bad_sup = 1'b0;
        bad_chg = 1'b0;
        bad_save = 1'b0;
        for (int i = 0; i < NUM_COND; i++) begin
            if (picks(cond_id, i)) begin
                sel_any = 1'b1;
                if (!SUPPORTED_MASK[i]) begin
                    bad_sup = 1'b1;
                end
                if (!CHANGEABLE_MASK[i]) begin
                    bad_chg = 1'b1;
                end
                if (!SAVABLE_MASK[i]) begin
                    bad_save = 1'b1;
                end
            end
        end
        case (sub_code)
            SUB_RESTORE: begin // [R1] [R6]
                abort = !extended_power_feature_in || !sel_any || bad_sup
                        || bad_chg || (save_bit && bad_save);
            end
            SUB_GOTO: begin // [R8] [R12]
                abort = !extended_power_feature_in || (cond_id == ID_ALL)
                        || !sel_any || bad_sup;
            end
            SUB_SET_TIMER: begin // [R13]
                abort = !extended_power_feature_in || !sel_any || bad_sup
                        || bad_chg || (save_bit && bad_save);
            end
            default: begin
                abort = 1'b1;
            end
        endcase
    end

    // next values of settings, flags and power condition
    always_comb begin
        next_state = state;
        next_cur_timer = cur_timer;
        next_saved_timer = saved_timer;
        next_cur_en = cur_timer_en_out;
        next_saved_en = saved_en;
        next_done = 1'b0;
        next_err = command_error_flags_out;
        next_stat = command_status_flags_out;
        next_active = power_cond_active_out;
        next_id = power_cond_id_out;
        next_halted = timers_halted_out;
        // enter the condition once completion has been shown
        if (state == PCS_ENTER) begin
            next_active = 1'b1; // [R10]
            next_state = PCS_IDLE;
        end
        if (cmd_valid_in) begin
            // any new command ends a forced condition
            next_active = 1'b0; // [R11]
            next_halted = 1'b0;
            next_state = PCS_IDLE;
        end
        if (epc_cmd) begin
            next_done = 1'b1;
            if (abort) begin
                next_err = ERR_ABORT; // [R7] [R19]
                next_stat = STAT_ABORT;
            end else begin
                next_err = ERR_RESET;
                next_stat = STAT_RESET;
                for (int i = 0; i < NUM_COND; i++) begin
                    if (picks(cond_id, i)) begin
                        case (sub_code)
                            SUB_RESTORE: begin
                                if (sector_number_in[BIT_DEFAULT]) begin
                                    next_cur_timer[i] = DEFAULT_TIMER; // [R3]
                                    next_cur_en[i] = DEFAULT_EN_MASK[i];
                                end else begin
                                    next_cur_timer[i] = saved_timer[i]; // [R4]
                                    next_cur_en[i] = saved_en[i];
                                end
                                if (save_bit && SAVABLE_MASK[i]) begin
                                    next_saved_timer[i] = next_cur_timer[i]; // [R5]
                                end
                            end
                            SUB_SET_TIMER: begin
                                next_cur_timer[i] = req_timer; // [R15]
                                next_cur_en[i] = sector_number_in[BIT_ENABLE]
                                                 && raw_nonzero; // [R16]
                                if (save_bit && SAVABLE_MASK[i]) begin
                                    next_saved_timer[i] = req_timer; // [R17]
                                    next_saved_en[i] = next_cur_en[i];
                                end
                            end
                            default: begin
                                next_cur_en[i] = cur_timer_en_out[i];
                            end
                        endcase
                    end
                end
                if (sub_code == SUB_GOTO) begin
                    next_halted = 1'b1; // [R9]
                    next_id = cond_id;
                    next_state = PCS_ENTER; // [R10]
                end
            end
        end
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------

    // settings and completion flags
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= PCS_IDLE;
            for (int i = 0; i < NUM_COND; i++) begin
                cur_timer[i] <= DEFAULT_TIMER;
                saved_timer[i] <= DEFAULT_TIMER;
            end
            saved_en <= DEFAULT_EN_MASK;
            cur_timer_en_out <= DEFAULT_EN_MASK;
            done_out <= 1'b0;
            command_error_flags_out <= ERR_RESET;
            command_status_flags_out <= STAT_RESET;
            power_cond_active_out <= 1'b0; // [R11]
            power_cond_id_out <= 8'h00;
            timers_halted_out <= 1'b0;
        end else begin
            state <= next_state;
            cur_timer <= next_cur_timer;
            saved_timer <= next_saved_timer;
            saved_en <= next_saved_en;
            cur_timer_en_out <= next_cur_en;
            done_out <= next_done;
            command_error_flags_out <= next_err;
            command_status_flags_out <= next_stat;
            power_cond_active_out <= next_active;
            power_cond_id_out <= next_id;
            timers_halted_out <= next_halted;
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------

    // every feature command of this kind completes next cycle
    done_follow_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        epc_cmd |=> done_out && !command_status_flags_out[7]) // [R7]
        else $error("completion pulse missing");

    // error bit in status mirrors abort bit
    abort_status_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        done_out |-> (command_status_flags_out[STAT_ERROR_BIT]
        == command_error_flags_out[ERR_ABORT_BIT])) // [R7]
        else $error("status and error flags disagree");

    // disabled feature aborts and leaves enables alone
    feat_off_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        epc_cmd && !extended_power_feature_in
        |=> command_error_flags_out == ERR_ABORT
        && $stable(cur_timer_en_out)) // [R6] [R19]
        else $error("disabled feature not aborted");

    // go-to with all-ones identifier aborts
    goto_all_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        epc_cmd && sub_code == SUB_GOTO && cond_id == ID_ALL
        |=> command_error_flags_out[ERR_ABORT_BIT] ##1 !power_cond_active_out) // [R12]
        else $error("go-to with all ones not aborted");

    // successful go-to halts timers, then enters the condition
    goto_enter_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        done_out && state == PCS_ENTER && !cmd_valid_in
        |-> timers_halted_out ##1 power_cond_active_out) // [R9] [R10]
        else $error("go-to did not enter condition");

    // entered condition holds until the next command
    cond_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        power_cond_active_out && !cmd_valid_in |=> power_cond_active_out) // [R11]
        else $error("condition left without a command");

    // command ends the forced condition
    cond_leave_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        cmd_valid_in |=> !power_cond_active_out) // [R11]
        else $error("condition not left on command");

    // set-timer with enable clear disables condition zero
    timer_off_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        epc_cmd && sub_code == SUB_SET_TIMER && cond_id == 8'h00
        && !abort && !sector_number_in[BIT_ENABLE]
        |=> !cur_timer_en_out[0]) // [R16]
        else $error("timer left enabled");

    // set-timer with enable and nonzero value enables condition zero
    timer_on_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        epc_cmd && sub_code == SUB_SET_TIMER && cond_id == 8'h00
        && !abort && sector_number_in[BIT_ENABLE] && raw_nonzero
        |=> cur_timer_en_out[0] && cur_timer[0] <= TIMER_MAX) // [R15] [R18]
        else $error("timer not enabled");

    // largest minute count is clamped down to the maximum
    timer_clamp_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        epc_cmd && sub_code == SUB_SET_TIMER && cond_id == 8'h00 && !abort
        && sector_number_in[BIT_UNITS] && {cyl_high_in, cyl_low_in} == 16'hFFFF
        |=> cur_timer[0] == TIMER_MAX) // [R18]
        else $error("timer not clamped");

    // restore from defaults loads default enables
    restore_def_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        epc_cmd && sub_code == SUB_RESTORE && sector_number_in[BIT_DEFAULT]
        && !abort && cond_id == 8'h00
        |=> cur_timer_en_out[0] == DEFAULT_EN_MASK[0]
        && cur_timer[0] == DEFAULT_TIMER) // [R3]
        else $error("default restore wrong");

endmodule : pcs_handler

/* pcs_host_model.sv */
// host side model that issues feature-setting commands to the handler
`timescale 1ns/1ps
module pcs_host_model (
    input wire logic core_clk_in,
    output logic cmd_valid_out,
    output logic [7:0] feature_out,
    output logic [7:0] sector_count_out,
    output logic [7:0] sector_number_out,
    output logic [7:0] cyl_low_out,
    output logic [7:0] cyl_high_out,
    output logic extended_power_feature_out
);
    // idle bus and feature set enabled at start
    initial begin
        cmd_valid_out = 1'b0;
        feature_out = 8'h00;
        sector_count_out = 8'h00;
        sector_number_out = 8'h00;
        cyl_low_out = 8'h00;
        cyl_high_out = 8'h00;
        extended_power_feature_out = 1'b1;
    end

    // -----------------------------------------------------------
    // command tasks, called at a rising edge
    // -----------------------------------------------------------
    // raise one command, held until the edge that takes it
    task automatic send(input logic [7:0] feat, input logic [7:0] id, input logic [7:0] num,
                        input logic [15:0] tmr);
        cmd_valid_out <= 1'b1;
        feature_out <= feat;
        sector_count_out <= id;
        sector_number_out <= num;
        cyl_high_out <= tmr[15:8];
        cyl_low_out <= tmr[7:0];
        @(posedge core_clk_in);
    endtask : send

    // release the strobe; released data lines show the inverse of their last value
    task automatic idle();
        cmd_valid_out <= 1'b0;
        feature_out <= ~feature_out;
        sector_count_out <= ~sector_count_out;
        sector_number_out <= ~sector_number_out;
        cyl_low_out <= ~cyl_low_out;
        cyl_high_out <= ~cyl_high_out;
    endtask : idle

    // feature set enable level
    task automatic set_feature(input logic on);
        extended_power_feature_out <= on;
    endtask : set_feature
endmodule : pcs_host_model

/* tb_pcs_handler.sv */
// self-checking testbench for the power-condition subcommand handler
`timescale 1ns/1ps
module tb_pcs_handler;
    import pcs_pkg::*;
    logic core_clk_in, resetn_in, cmd_valid, epf, done, active, halted;
    logic [7:0] feat, cnt, num, cl, ch, err, stat, cid;
    logic [1:0] en;
    int miscompares = 0;
    int cmp_count = 0;
    // abort table: subcode, id, upper flags, feature enable
    logic [3:0] ab_sub [8] = '{4'h2, 4'h0, 4'h0, 4'h1, 4'h1, 4'h4, 4'h2, 4'h1};
    logic [7:0] ab_id [8] = '{8'h01, 8'h01, 8'h05, 8'hFF, 8'h05, 8'h00, 8'h00, 8'h00};
    logic [3:0] ab_flg [8] = '{4'h1, 4'h1, 4'h4, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0};
    logic ab_epf [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    // id 1 is not savable so save requests on it must be refused
    pcs_handler #(.SAVABLE_MASK(2'h1)) i_pcs_handler (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid),
        .feature_in(feat), .sector_count_in(cnt), .sector_number_in(num),
        .cyl_low_in(cl), .cyl_high_in(ch), .extended_power_feature_in(epf),
        .done_out(done), .command_error_flags_out(err), .command_status_flags_out(stat),
        .power_cond_active_out(active), .power_cond_id_out(cid),
        .timers_halted_out(halted), .cur_timer_en_out(en)
    );
    pcs_host_model u_host (
        .core_clk_in(core_clk_in), .cmd_valid_out(cmd_valid), .feature_out(feat),
        .sector_count_out(cnt), .sector_number_out(num), .cyl_low_out(cl),
        .cyl_high_out(ch), .extended_power_feature_out(epf)
    );

    // clock at 200 MHz
    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    // -----------------------------------------------------------
    // compare and command tasks
    // -----------------------------------------------------------
    task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task automatic check_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    // one command, completion checked 1 ns after the edge that takes it; ends at a rising edge
    task automatic do_cmd(input logic [3:0] sub, input logic [7:0] id, input logic [3:0] flg,
                          input logic [15:0] tmr, input logic abort, input logic [1:0] exp_en);
        u_host.send(8'h4A, id, {flg, sub}, tmr);
        u_host.idle();
        #1;
        check_bit("done", 1'b1, done);
        check_val("error flags", abort ? ERR_ABORT : ERR_RESET, err);
        check_val("status flags", abort ? STAT_ABORT : STAT_RESET, stat);
        check_val("timer enables", {6'h00, exp_en}, {6'h00, en});
        @(posedge core_clk_in);
    endtask : do_cmd

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // watchdog, far beyond the roughly 60 cycles the tests need
    initial begin
        #20000;
        miscompares++;
        give_verdict();
    end

    // -----------------------------------------------------------
    // test sequence
    // -----------------------------------------------------------
    initial begin
        resetn_in = 1'b0;
        repeat (10) @(posedge core_clk_in);
        #1;
        check_val("status at reset", STAT_RESET, stat);
        check_val("error at reset", ERR_RESET, err);
        check_val("enables at reset", 8'h03, {6'h00, en});
        check_bit("active at reset", 1'b0, active);
        @(posedge core_clk_in);
        resetn_in <= 1'b1;
        @(posedge core_clk_in);
        $display("test reset finished");
        do_cmd(SUB_SET_TIMER, 8'h00, 4'h2, 16'h0000, 1'b0, 2'b10);
        do_cmd(SUB_SET_TIMER, 8'h00, 4'h2, 16'h0005, 1'b0, 2'b11);
        do_cmd(SUB_SET_TIMER, 8'h00, 4'h1, 16'h0005, 1'b0, 2'b10);
        do_cmd(SUB_SET_TIMER, 8'h00, 4'hA, 16'hFFFF, 1'b0, 2'b11);
        do_cmd(SUB_RESTORE, 8'h00, 4'h0, 16'h0000, 1'b0, 2'b10);
        do_cmd(SUB_RESTORE, 8'h00, 4'h4, 16'h0000, 1'b0, 2'b11);
        do_cmd(SUB_RESTORE, 8'h00, 4'h1, 16'h0000, 1'b0, 2'b10);
        do_cmd(SUB_SET_TIMER, 8'hFF, 4'h0, 16'h0003, 1'b0, 2'b00);
        do_cmd(SUB_RESTORE, 8'hFF, 4'h4, 16'h0000, 1'b0, 2'b11);
        $display("test timer settings finished");
        for (int i = 0; i < 8; i++) begin
            u_host.set_feature(ab_epf[i]);
            do_cmd(ab_sub[i], ab_id[i], ab_flg[i], 16'h0000, 1'b1, 2'b11);
        end
        u_host.set_feature(1'b1);
        $display("test refusals finished");
        do_cmd(SUB_GOTO, 8'h01, 4'h0, 16'h0000, 1'b0, 2'b11);
        #1;
        check_bit("halted", 1'b1, halted);
        check_val("condition id", 8'h01, cid);
        check_bit("entered", 1'b1, active);
        repeat (4) @(posedge core_clk_in);
        #1;
        check_bit("still entered", 1'b1, active);
        @(posedge core_clk_in);
        u_host.send(8'h02, 8'h00, 8'h00, 16'h0000);
        u_host.idle();
        #1;
        check_bit("left condition", 1'b0, active);
        check_bit("other feature done", 1'b0, done);
        @(posedge core_clk_in);
        $display("test go-to finished");
        u_host.send(8'h4A, 8'h00, 8'h40, 16'h0000);
        // second command raised at the edge that takes the first
        fork
            u_host.send(8'h4A, 8'h00, 8'h02, 16'h0000);
            begin
                #1;
                check_bit("first done", 1'b1, done);
                check_val("enables after first", 8'h03, {6'h00, en});
            end
        join
        u_host.idle();
        #1;
        check_bit("second done", 1'b1, done);
        check_val("enables after pair", 8'h02, {6'h00, en});
        @(posedge core_clk_in);
        $display("test back to back finished");
        give_verdict();
    end
endmodule : tb_pcs_handler
